// >>> hw/spf_pkg.sv
/*
 * spf_pkg: constants for the single-port sram fifo.
 * assumes a single 200 MHz clock domain and synchronous reset.
 */
package spf_pkg;
  localparam int SPF_BANK_DEPTH = 16;
  localparam int SPF_BANK_AW = 4;
  localparam int SPF_SLICE_W = 4;
  localparam int SPF_BANKS = 2;
  localparam int SPF_SLICES = 2;
  localparam int SPF_AW = 5;
  localparam int SPF_DEPTH = 32;
  localparam int SPF_DW = 8;
  localparam logic [SPF_AW-1:0] SPF_PTR_RST = 5'h00;
  localparam logic [SPF_AW-1:0] SPF_PTR_LAST = 5'h1F;
  localparam logic [SPF_AW:0] SPF_CNT_RST = 6'h00;
  localparam logic [SPF_AW:0] SPF_CNT_FULL = 6'h20;
  localparam int SPF_SERVICE_CYC = 2;
  typedef enum logic [1:0] {SPF_IDLE, SPF_RD2, SPF_WR2} spf_state_e;
endpackage : spf_pkg

// >>> hw/spf_fifo.sv
/*
 * spf_fifo: fifo on single-ported storage, 32 words of 8 bits built from
 * 16x4 banks (two deep, two wide). four-phase request/acknowledge on both
 * sides; inputs are taken as synchronous to i_clk.
 */
// Summary of operation
// - read and write pointers share the one storage address via a mux.
// - each accepted request finishes within three internal clock cycles, two unless a write waits behind a read.
// - storage is time shared; a read access is followed by a write if one is pending.
// - simultaneous requests: read first when holding data, else write first.
// - full and empty come from the word count cnt_ff, not the pointers.
// - no read acknowledge when empty, no write acknowledge when full.
// - synchronous inside; parties request and wait for acknowledge.
// - depth from two 16x4 banks, write enable decoded from top address bit.
// - the same address bit selects which bank drives read data.
// - width from parallel banks sharing address and write enable.
`timescale 1ns/1ps

// ============================================================
// 16x4 storage bank
module spf_bank (
  input wire logic i_clk, // clock
  input wire logic i_ce, // clock enable
  input wire logic i_we, // write enable
  input wire logic [3:0] i_addr, // address
  input wire logic [3:0] i_wdata, // write data
  output logic [3:0] o_rdata // asynchronous read data
);
  logic [3:0] mem [16];
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
  // combinational read lets a read slot capture its word in one cycle
  assign o_rdata = mem[i_addr];
endmodule : spf_bank

// ============================================================
// fifo top
module spf_fifo
  import spf_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_ce, // clock enable
  input wire logic i_wr_req, // producer request, level
  input wire logic [7:0] i_wr_data, // producer data, held with request
  output logic o_wr_ack, // producer acknowledge, level
  input wire logic i_rd_req, // consumer request, level
  output logic o_rd_ack, // consumer acknowledge, level
  output logic [7:0] o_rd_data, // consumer data, valid with ack
  output logic o_full, // buffer full
  output logic o_empty // buffer empty
);
  spf_state_e state_ff, nxt_state;
  logic [SPF_AW-1:0] rptr_ff, nxt_rptr, wptr_ff, nxt_wptr;
  logic [SPF_AW:0] cnt_ff, nxt_cnt;
  logic wr_ack_ff, nxt_wr_ack, rd_ack_ff, nxt_rd_ack;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [SPF_AW-1:0] addr;
  logic wr_en, use_wr;
  logic [7:0] mem_rdata;
  logic [SPF_BANKS*SPF_SLICES*4-1:0] bank_out;
  logic can_rd, can_wr, rd_new, wr_new;

  // ============================================================
  // flags
  assign o_empty = (cnt_ff == SPF_CNT_RST);
  assign o_full = (cnt_ff == SPF_CNT_FULL);
  // a request is new only after its previous ack has been dropped
  assign rd_new = i_rd_req && !rd_ack_ff;
  assign wr_new = i_wr_req && !wr_ack_ff;
  assign can_rd = rd_new && !o_empty;
  assign can_wr = wr_new && !o_full;

  // ============================================================
  // storage: address mux and bank decode
  assign use_wr = (state_ff == SPF_WR2);
  assign addr = use_wr ? wptr_ff : rptr_ff;
  assign wr_en = use_wr && i_ce;

  genvar gb, gs;
  generate
    for (gb = 0; gb < SPF_BANKS; gb++) begin : g_bank
      for (gs = 0; gs < SPF_SLICES; gs++) begin : g_slice
        spf_bank u_bank (
          .i_clk(i_clk),
          .i_ce(i_ce),
          .i_we(wr_en && (addr[SPF_AW-1] == 1'(gb))),
          .i_addr(addr[SPF_BANK_AW-1:0]),
          .i_wdata(i_wr_data[gs*4 +: 4]),
          .o_rdata(bank_out[(gb*SPF_SLICES+gs)*4 +: 4])
        );
      end
    end
  endgenerate
  // one-hot bank select on the shared bus stands in for tristate drivers
  assign mem_rdata = addr[SPF_AW-1] ? bank_out[15:8] : bank_out[7:0];

  // ============================================================
  // control
  always_comb begin
    nxt_state = state_ff;
    nxt_rptr = rptr_ff;
    nxt_wptr = wptr_ff;
    nxt_cnt = cnt_ff;
    nxt_rdata = rdata_ff;
    nxt_wr_ack = wr_ack_ff && i_wr_req;
    nxt_rd_ack = rd_ack_ff && i_rd_req;
    case (state_ff)
      SPF_IDLE: begin
        if (can_rd) begin
          // read phase, then the write slot follows if a write is pending
          nxt_rdata = mem_rdata;
          nxt_rptr = (rptr_ff == SPF_PTR_LAST) ? SPF_PTR_RST :
                     rptr_ff + 5'h01;
          nxt_cnt = cnt_ff - 6'h01;
          nxt_rd_ack = 1'b1;
          nxt_state = SPF_RD2;
        end else if (can_wr) begin
          nxt_state = SPF_WR2;
        end
      end
      SPF_RD2: begin
        // second cycle of a read slot; go to write slot if pending
        nxt_state = can_wr ? SPF_WR2 : SPF_IDLE;
        if (!can_wr) begin
          nxt_state = SPF_IDLE;
        end
      end
      SPF_WR2: begin
        // the request was qualified when the slot was granted; the
        // producer holds its data until ack, so the write needs no recheck
        nxt_wptr = (wptr_ff == SPF_PTR_LAST) ? SPF_PTR_RST :
                   wptr_ff + 5'h01;
        nxt_cnt = cnt_ff + 6'h01;
        nxt_wr_ack = 1'b1;
        nxt_state = SPF_IDLE;
      end
      default: nxt_state = SPF_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= SPF_IDLE;
      rptr_ff <= SPF_PTR_RST;
      wptr_ff <= SPF_PTR_RST;
      cnt_ff <= SPF_CNT_RST;
      rdata_ff <= 8'h00;
      wr_ack_ff <= 1'b0;
      rd_ack_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      rptr_ff <= nxt_rptr;
      wptr_ff <= nxt_wptr;
      cnt_ff <= nxt_cnt;
      rdata_ff <= nxt_rdata;
      wr_ack_ff <= nxt_wr_ack;
      rd_ack_ff <= nxt_rd_ack;
    end
  end

  assign o_wr_ack = wr_ack_ff;
  assign o_rd_ack = rd_ack_ff;
  assign o_rd_data = rdata_ff;

  // ============================================================
  // checks
  sequence s_wr_start;
    state_ff == SPF_IDLE && !can_rd && can_wr && i_ce;
  endsequence
  sequence s_wr_done;
    state_ff == SPF_WR2 ##1 o_wr_ack;
  endsequence
  sequence s_rd_slot;
    state_ff == SPF_RD2 && can_wr && i_ce;
  endsequence

  a_wr_two_cycles: assert property (@(posedge i_clk) disable iff (i_rst)
    s_wr_start ##1 i_ce |-> s_wr_done)
    else $error("write not acknowledged in two cycles");
  a_rd_ack_next: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_ff == SPF_IDLE && can_rd && i_ce) |=> o_rd_ack)
    else $error("read not acknowledged next cycle");
  a_rd_priority: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_ff == SPF_IDLE && can_rd && can_wr && i_ce) |=>
    state_ff == SPF_RD2)
    else $error("read not served first");
  a_empty_no_rd: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_empty && !o_rd_ack && i_ce) |=> !o_rd_ack)
    else $error("read acknowledged while empty");
  a_full_no_wr: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_full && !o_wr_ack && state_ff != SPF_WR2 && i_ce) |=> !o_wr_ack)
    else $error("write acknowledged while full");
  a_flags_excl: assert property (@(posedge i_clk) disable iff (i_rst)
    !(o_full && o_empty) && cnt_ff <= SPF_CNT_FULL)
    else $error("full and empty together");
  a_wptr_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_ff == SPF_WR2 && i_ce) |=>
    wptr_ff == (($past(wptr_ff) == SPF_PTR_LAST) ? SPF_PTR_RST :
                $past(wptr_ff) + 5'h01))
    else $error("write pointer step wrong");
  a_addr_mux: assert property (@(posedge i_clk) disable iff (i_rst)
    addr == (state_ff == SPF_WR2 ? wptr_ff : rptr_ff))
    else $error("address mux wrong");
  a_ack_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_wr_ack && i_wr_req && i_ce) |=> o_wr_ack)
    else $error("write ack dropped before request");
  a_rd_then_wr: assert property (@(posedge i_clk) disable iff (i_rst)
    s_rd_slot |=> state_ff == SPF_WR2)
    else $error("write slot did not follow read slot");
  a_rptr_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_ff == SPF_IDLE && can_rd && i_ce) |=>
    rptr_ff == (($past(rptr_ff) == SPF_PTR_LAST) ? SPF_PTR_RST :
                $past(rptr_ff) + 5'h01))
    else $error("read pointer step wrong");
  // pointers alone cannot tell full from empty, hence the count
  a_ptr_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    (rptr_ff == wptr_ff) == (o_empty || o_full))
    else $error("flags disagree with pointers");
  a_rd_data_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rd_ack |=> $stable(o_rd_data))
    else $error("read data changed while acknowledged");
endmodule : spf_fifo

// >>> tb/spf_reader.sv
/* spf_reader: consumer model, four-phase read handshake.
   assumes a registered read acknowledge on i_clk. */
`timescale 1ns/1ps
// ==============================
// consumer model
module spf_reader (
  input wire logic i_clk, // clock
  input wire logic i_go, // keep a read request up
  input wire logic i_ack, // fifo read ack
  input wire logic [7:0] i_data, // fifo read data
  output logic o_req, // read request
  output logic [7:0] o_word // last word taken
);
  initial o_req = 1'b0;
  initial o_word = 8'h00;
  // an unanswered request is withdrawn when i_go falls, so refusals end
  always @(negedge i_clk) begin
    if (o_req && i_ack) begin
      o_req <= 1'b0;
      o_word <= i_data;
    end else if (!i_ack) o_req <= i_go;
  end
endmodule : spf_reader

// >>> tb/spf_fifo_test.sv
/* spf_fifo_test: self-checking bench for spf_fifo.
   assumes spf_reader as consumer; producer is driven here. */
`timescale 1ns/1ps
// ==============================
// bench top
module spf_fifo_test;
  logic clk, rst, ce, wr_req, go, rd_req, wr_ack, rd_ack, full, empty;
  logic [7:0] wr_data, rd_data, word;
  int err_total = 0;
  int checked = 0;
  int nw, nr;
  time tw, tr;
  spf_fifo i_spf_fifo (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_wr_req(wr_req), .i_wr_data(wr_data), .o_wr_ack(wr_ack),
    .i_rd_req(rd_req), .o_rd_ack(rd_ack), .o_rd_data(rd_data),
    .o_full(full), .o_empty(empty));
  spf_reader i_spf_reader (.i_clk(clk), .i_go(go), .i_ack(rd_ack),
    .i_data(rd_data), .o_req(rd_req), .o_word(word));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ==============================
  // handshakes; nw/nr count edges to ack, equal to lim when refused
  task automatic put(input logic [7:0] d, input int lim);
    @(negedge clk);
    wr_req = 1'b1;
    wr_data = d;
    for (nw = 0; wr_ack !== 1'b1 && nw < lim; nw++) @(posedge clk) #1;
    tw = $time;
    @(negedge clk);
    wr_req = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, wr_ack}, 8'h00);
  endtask : put
  task automatic get(input int lim);
    // go moves off the model's falling edge so its sample never races
    @(posedge clk) #1;
    go = 1'b1;
    for (nr = 0; rd_ack !== 1'b1 && nr < lim; nr++) @(posedge clk) #1;
    tr = $time;
    go = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, rd_ack}, 8'h00);
  endtask : get
  // ==============================
  // scenarios
  task automatic t_fill;
    for (int i = 0; i < 32; i++) begin
      put(8'(i * 7 + 3), 8);
      chk(8'(nw <= 3), 8'h01);
    end
    chk({6'h00, full, empty}, 8'h02);
    put(8'hEE, 8);
    chk(8'(nw), 8'h08);
  endtask : t_fill
  task automatic t_drain;
    for (int i = 0; i < 32; i++) begin
      get(8);
      chk(8'(nr <= 2), 8'h01);
      chk(word, 8'(i * 7 + 3));
    end
    chk({6'h00, full, empty}, 8'h01);
    get(8);
    chk(8'(nr), 8'h08);
  endtask : t_drain
  task automatic t_both;
    fork
      put(8'hA5, 20);
      get(20);
    join
    chk(8'(tw < tr), 8'h01);
    chk(word, 8'hA5);
    put(8'h3C, 8);
    fork
      put(8'h5A, 20);
      get(20);
    join
    chk(8'(tr < tw), 8'h01);
    chk(word, 8'h3C);
    get(8);
    chk(word, 8'h5A);
  endtask : t_both
  task automatic t_freeze;
    @(negedge clk);
    ce = 1'b0;
    wr_req = 1'b1;
    wr_data = 8'h96;
    repeat (4) @(negedge clk);
    chk({6'h00, wr_ack, empty}, 8'h01);
    ce = 1'b1;
    put(8'h96, 8);
    chk(8'(nw), 8'h01);
    get(8);
    chk(word, 8'h96);
  endtask : t_freeze
  task automatic t_reset;
    put(8'h11, 8);
    put(8'h22, 8);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({4'h0, full, empty, wr_ack, rd_ack}, 8'h04);
    chk(rd_data, 8'h00);
    put(8'h33, 8);
    get(8);
    chk(word, 8'h33);
  endtask : t_reset
  task automatic conclude;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wr_req = 1'b0;
    wr_data = 8'h00;
    go = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({4'h0, full, empty, wr_ack, rd_ack}, 8'h04);
    chk(rd_data, 8'h00);
    t_fill;
    t_drain;
    t_both;
    t_freeze;
    t_reset;
    conclude;
  end
  // whole run needs about 1.8 us
  initial begin
    #50000;
    err_total++;
    conclude;
  end
endmodule : spf_fifo_test
